// ### rtl/digipot_pkg.sv
package digipot_pkg;

   // One sixteen-bit command word as it arrives, most significant bit first.
   typedef struct packed {
      logic [1:0] lead;
      logic [3:0] cmd;
      logic [9:0] data;
   } frame_t;

   // Progress of a one-time-programmable store.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROGRAM,
      ST_VERIFY
   } store_state_t;

endpackage : digipot_pkg

// ### rtl/digipot_regs.svh
`ifndef DIGIPOT_REGS_SVH
`define DIGIPOT_REGS_SVH

// Command codes carried in the four command bits of a frame.
`define CMD_NOP 4'h0
`define CMD_WIPER_WRITE 4'h1
`define CMD_WIPER_READ 4'h2
`define CMD_OTP_STORE 4'h3
`define CMD_OTP_RELOAD 4'h4
`define CMD_OTP_READ 4'h5
`define CMD_CTRL_WRITE 4'h6
`define CMD_CTRL_READ 4'h7
`define CMD_SHUTDOWN 4'h8

// Bit positions inside control_flags.
`define CTRL_OTP_EN 0
`define CTRL_WIPER_WE 1
`define CTRL_CAL_SEL 2
`define CTRL_SUCCESS 3

// Reset values.
`define CTRL_RESET 4'h0
`define WIPER_MIDSCALE 10'h200

// One-time-programmable store layout and readback selectors.
`define OTP_DEPTH 20
`define SEL_STATUS_LO 5'h14
`define SEL_STATUS_HI 5'h15
`define THERM_SPLIT 10

// Frame length and store timing.
`define FRAME_BITS 16
`define STORE_TIME_US 8000
`define REF_CLK_MHZ 10

`endif

// ### rtl/digipot_serial_command_ctrl.sv
// How it works
// R1 - Sixteen-bit frame: zeros, command, ten data bits.
// R2 - Low-resolution variant ignores two lowest wiper bits.
// R3 - Decode word when frame select returns high.
// R4 - Accept only whole multiples of sixteen bits.
// R5 - Serial clock may stop between frames.
// R6 - Wiper register sets position, unlimited writes.
// R7 - Command 1 writes wiper if enabled; 0 idles.
// R8 - Command 2 returns wiper in next frame.
// R9 - Command 3 stores wiper if program enabled.
// R10 - Command 4 reloads wiper despite write protect.
// R11 - Command 5 selects stored word or status.
// R12 - Command 6 loads four control bits.
// R13 - Command 7 returns control bits next frame.
// R14 - Command 8 bit zero enters/leaves shutdown.
// R15 - Read value fills last ten output bits.
// R16 - Store takes eight ms, commands locked.
// R17 - Ready output shows store and verify done.
// R18 - Twenty locations, each store verified.
// R19 - Control bit three reports last store result.
// R20 - Control bit one defaults zero, blocks writes.
// R21 - Control bit zero defaults zero, blocks stores.
// R22 - Control bit two selects calibration mode.
// R23 - Reset pin rise restores wiper and control.
// R24 - Input bits taken on falling clock edges.
// R25 - Output bits change on rising clock edges.
// R26 - Short frame is discarded without update.
// R27 - Power-up wiper midscale or last stored; nrst always loads midscale and clears the used count.
`timescale 1ns/100ps
`default_nettype none
`include "digipot_regs.svh"

module digipot_serial_command_ctrl
   import digipot_pkg::*;
#(
   parameter bit LOW_RES = 1'b0,
   parameter int STORE_CYCLES = `STORE_TIME_US * `REF_CLK_MHZ
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic link_sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire logic reset_pin,
   output logic serial_out_od_o,
   output logic serial_out_od_oe,
   output logic ready_o,
   output logic [9:0] wiper_o,
   output logic [3:0] control_flags_o,
   output logic shutdown_o,
   output logic calibration_select_o
);

   localparam int DEPTH = `OTP_DEPTH;
   localparam logic [9:0] LOW_MASK = LOW_RES ? 10'h3FC : 10'h3FF;

   logic [15:0] rx_word;
   logic [15:0] tx_word;
   logic frame_ok;
   logic sync_meta;
   logic sync_s;
   logic sync_d;
   logic rst_meta;
   logic rst_s;
   logic rst_d;
   logic [9:0] wiper_register;
   logic [3:0] control_flags;
   logic shutdown;
   logic [4:0] otp_count;
   logic [4:0] prog_idx;
   logic [9:0] prog_value;
   logic [31:0] timer;
   logic [9:0] otp_store [0:DEPTH-1];
   store_state_t state;
   store_state_t next_state;

   // Serial front end, running on the link clock.
   serial_link_shift link (
      .link_sclk(link_sclk),
      .nrst(nrst),
      .sync_n(sync_n),
      .din(din),
      .tx_word(tx_word),
      .rx_word(rx_word),
      .frame_ok(frame_ok),
      .sdo_o(serial_out_od_o),
      .sdo_oe(serial_out_od_oe)
   );

   // Frame select and the reset pin come from outside and pass two flip-flops.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync_meta <= 1'b1;
         sync_s <= 1'b1;
         sync_d <= 1'b1;
         rst_meta <= 1'b1;
         rst_s <= 1'b1;
         rst_d <= 1'b1;
      end else begin
         sync_meta <= sync_n;
         sync_s <= sync_meta;
         sync_d <= sync_s;
         rst_meta <= reset_pin;
         rst_s <= rst_meta;
         rst_d <= rst_s;
      end
   end

   // Frame end is seen on the local clock, so no link clock edge is needed after it.
   frame_t frame;
   logic frame_end;
   logic rst_rise;
   logic idle;
   logic accept;
   assign frame = rx_word;
   assign frame_end = sync_s & ~sync_d; // R3 R5
   assign rst_rise = rst_s & ~rst_d; // R23
   assign idle = (state == ST_IDLE);
   assign accept = frame_end & frame_ok & idle & (frame.lead == 2'b00); // R1 R4 R16 R26

   // Command decode.
   logic do_write;
   logic do_store;
   logic do_reload;
   logic do_ctrl;
   logic do_shut;
   logic do_read;
   logic otp_full;
   assign do_write = accept & (frame.cmd == `CMD_WIPER_WRITE)
                     & control_flags[`CTRL_WIPER_WE]; // R7 R20
   assign do_store = accept & (frame.cmd == `CMD_OTP_STORE)
                     & control_flags[`CTRL_OTP_EN]; // R9 R21
   assign do_reload = accept & (frame.cmd == `CMD_OTP_RELOAD); // R10
   assign do_ctrl = accept & (frame.cmd == `CMD_CTRL_WRITE); // R12
   assign do_shut = accept & (frame.cmd == `CMD_SHUTDOWN); // R14
   assign do_read = accept & ((frame.cmd == `CMD_WIPER_READ) | (frame.cmd == `CMD_OTP_READ)
                     | (frame.cmd == `CMD_CTRL_READ));
   assign otp_full = (otp_count == 5'(DEPTH));

   // Value a reload brings back: the latest stored word, else midscale.
   logic [9:0] restore_value;
   logic [4:0] last_idx;
   assign last_idx = otp_count - 5'h01;
   assign restore_value = (otp_count == 5'h00) ? `WIPER_MIDSCALE
                          : otp_store[last_idx]; // R10 R23 R27

   // Thermometer code of how many locations are used, capped at the split.
   function automatic logic [9:0] therm(input logic [4:0] n);
      logic [9:0] t;
      t = 10'h000;
      for (int i = 0; i < `THERM_SPLIT; i++) begin
         t[i] = (5'(i) < n);
      end
      return t;
   endfunction : therm

   // Readback selection for the stored words and the two status words.
   logic [4:0] sel;
   logic [4:0] count_hi;
   logic [9:0] otp_read_value;
   assign sel = frame.data[4:0];
   assign count_hi = (otp_count > 5'(`THERM_SPLIT)) ? otp_count - 5'(`THERM_SPLIT) : 5'h00;
   assign otp_read_value = (sel == `SEL_STATUS_LO) ? therm(otp_count)
                           : (sel == `SEL_STATUS_HI) ? therm(count_hi)
                           : (sel < otp_count) ? otp_store[sel]
                           : 10'h000; // R11 R18

   // Answer shown in the next frame: a read value in the low ten bits, else an echo.
   logic [9:0] read_value;
   logic [15:0] next_tx;
   assign read_value = (frame.cmd == `CMD_WIPER_READ) ? (wiper_register & LOW_MASK)
                       : (frame.cmd == `CMD_OTP_READ) ? otp_read_value
                       : {6'h00, control_flags}; // R2 R8 R13
   assign next_tx = do_read ? {6'h00, read_value} : rx_word; // R15

   // Wiper register: reset pin first, then reload, then a permitted write.
   logic [9:0] next_wiper;
   assign next_wiper = (rst_rise | do_reload) ? restore_value
                       : do_write ? (frame.data & LOW_MASK)
                       : wiper_register; // R2 R6 R7 R10 R20 R23

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wiper_register <= `WIPER_MIDSCALE; // R27
      end else begin
         wiper_register <= next_wiper;
      end
   end

   // The answer word is held steady between frames for the link side to load.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_word <= 16'h0000;
      end else if (accept) begin
         tx_word <= next_tx;
      end
   end

   // Store sequencing: program for the full store time, then one verify cycle.
   logic store_done;
   logic verify_ok;
   assign store_done = (state == ST_PROGRAM) & (timer == 32'(STORE_CYCLES - 1));
   assign verify_ok = (otp_store[prog_idx] == prog_value); // R18

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (do_store & ~otp_full) begin
               next_state = ST_PROGRAM; // R9 R16
            end
         end
         ST_PROGRAM: begin
            if (store_done) begin
               next_state = ST_VERIFY;
            end
         end
         ST_VERIFY: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         timer <= 32'h0000_0000;
      end else begin
         state <= next_state;
         timer <= (state == ST_PROGRAM) ? timer + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   // Ready goes low for the whole program and verify, high again once done.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ready_o <= 1'b1;
      end else begin
         ready_o <= (next_state == ST_IDLE); // R17
      end
   end

   // Location index and value of the store in progress, plus the used count.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         otp_count <= 5'h00;
         prog_idx <= 5'h00;
         prog_value <= 10'h000;
      end else if (idle & do_store & ~otp_full) begin
         otp_count <= otp_count + 5'h01; // R18
         prog_idx <= otp_count;
         prog_value <= wiper_register & LOW_MASK; // R9
      end
   end

   // The one-time-programmable array itself; a location is written only once until nrst clears the used count.
   always_ff @(posedge ref_clk) begin
      if (idle & do_store & ~otp_full) begin
         otp_store[otp_count] <= wiper_register & LOW_MASK; // R9 R18
      end
   end

   // Control flags: the reset pin restores defaults, a store result sets bit three.
   logic [3:0] next_ctrl;
   always_comb begin
      next_ctrl = control_flags;
      if (do_ctrl) begin
         next_ctrl = frame.data[3:0]; // R12
      end
      if (do_store & otp_full) begin
         next_ctrl[`CTRL_SUCCESS] = 1'b0; // R19
      end
      if (state == ST_VERIFY) begin
         next_ctrl[`CTRL_SUCCESS] = verify_ok; // R19
      end
      if (rst_rise) begin
         next_ctrl = `CTRL_RESET; // R23
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         control_flags <= `CTRL_RESET; // R19 R20 R21 R22
      end else begin
         control_flags <= next_ctrl;
      end
   end

   // Shutdown leaves the wiper register untouched.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         shutdown <= 1'b0;
      end else if (do_shut) begin
         shutdown <= frame.data[0]; // R14
      end
   end

   // Outputs straight from the registers above.
   assign wiper_o = wiper_register; // R6
   assign control_flags_o = control_flags;
   assign shutdown_o = shutdown;
   assign calibration_select_o = control_flags[`CTRL_CAL_SEL]; // R22

   // Checks on the command logic, all on the local clock.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   sequence seq_store_start;
      idle && do_store && !otp_full;
   endsequence

   sequence seq_locked;
      (!ready_o && state != ST_IDLE) [*8];
   endsequence

   chk_store_locks: assert property (seq_store_start |=> seq_locked) // R16 R17
      else $error("store did not lock the command path");

   chk_lock_holds: assert property (
      (!idle && frame_end && !rst_rise) |=> ($stable(wiper_register) && $stable(tx_word))) // R16
      else $error("command changed state during a store");

   chk_write_gated: assert property (
      (accept && frame.cmd == `CMD_WIPER_WRITE && !control_flags[`CTRL_WIPER_WE] && !rst_rise)
      |=> $stable(wiper_register)) // R7 R20
      else $error("wiper written while protected");

   chk_write_loads: assert property (
      (do_write && !rst_rise) |=> (wiper_register == ($past(frame.data) & LOW_MASK))) // R7
      else $error("wiper write lost");

   chk_ctrl_load: assert property (
      (do_ctrl && !rst_rise && state != ST_VERIFY)
      |=> (control_flags == $past(frame.data[3:0]))) // R12
      else $error("control write lost");

   chk_reset_pin: assert property (
      rst_rise |=> (control_flags == `CTRL_RESET && wiper_register == $past(restore_value))) // R23
      else $error("reset pin did not restore");

   chk_short_frame: assert property (
      (frame_end && !frame_ok && !rst_rise)
      |=> ($stable(wiper_register) && $stable(tx_word) && $stable(shutdown))) // R26
      else $error("short frame changed state");

   chk_wiper_read: assert property (
      (do_read && frame.cmd == `CMD_WIPER_READ)
      |=> (tx_word == {6'h00, $past(wiper_register) & LOW_MASK})) // R8 R15
      else $error("wiper readback wrong");

   chk_reload_cmd: assert property (
      (do_reload && !rst_rise) |=> (wiper_register == $past(restore_value))) // R10
      else $error("reload did not restore wiper");

   chk_shutdown_bit: assert property (do_shut |=> (shutdown == $past(frame.data[0]))) // R14
      else $error("shutdown bit not taken");

   chk_low_bits: assert property (LOW_RES |-> (wiper_register[1:0] == 2'b00)) // R2
      else $error("low wiper bits set in reduced resolution");

endmodule : digipot_serial_command_ctrl
`default_nettype wire

// ### rtl/serial_link_shift.sv
`timescale 1ns/100ps
`default_nettype none
`include "digipot_regs.svh"

module serial_link_shift (
   input wire logic link_sclk,
   input wire logic nrst,
   input wire logic sync_n,
   input wire logic din,
   input wire logic [15:0] tx_word,
   output logic [15:0] rx_word,
   output logic frame_ok,
   output logic sdo_o,
   output logic sdo_oe
);

   logic frame_clr_n;
   logic rx_active;
   logic tx_active;
   logic seen_full;
   logic [3:0] bit_cnt;
   logic [15:0] out_shift;
   logic next_sdo;

   // Frame-scoped flags clear as soon as frame select goes high, with no clock needed.
   assign frame_clr_n = nrst & ~sync_n;

   // Length is good only for a whole number of sixteen-bit words; a frame with no clock edges keeps the previous frame's verdict.
   assign frame_ok = seen_full & (bit_cnt == 4'h0); // R4 R26

   // The first rising edge of a frame loads the answer; later ones walk the chain.
   assign next_sdo = tx_active ? out_shift[14] : tx_word[15];

   // Marks that at least one falling edge has been seen in this frame.
   always_ff @(negedge link_sclk or negedge frame_clr_n) begin
      if (!frame_clr_n) begin
         rx_active <= 1'b0;
      end else begin
         rx_active <= 1'b1;
      end
   end

   // Input bits are taken on falling edges, MSB first; the word holds after the frame.
   always_ff @(negedge link_sclk or negedge nrst) begin
      if (!nrst) begin
         rx_word <= 16'h0000;
         bit_cnt <= 4'h0;
         seen_full <= 1'b0;
      end else if (!sync_n) begin
         rx_word <= {rx_word[14:0], din}; // R1 R24
         bit_cnt <= rx_active ? bit_cnt + 4'h1 : 4'h1; // R4
         seen_full <= rx_active & (seen_full | (bit_cnt == 4'hF));
      end
   end

   // Marks that the answer has been loaded in this frame.
   always_ff @(posedge link_sclk or negedge frame_clr_n) begin
      if (!frame_clr_n) begin
         tx_active <= 1'b0;
      end else begin
         tx_active <= 1'b1;
      end
   end

   // Output bits change on rising edges so the host can take them on the next fall.
   always_ff @(posedge link_sclk or negedge nrst) begin
      if (!nrst) begin
         out_shift <= 16'h0000;
         sdo_o <= 1'b0;
      end else if (!sync_n) begin
         out_shift <= tx_active ? {out_shift[14:0], rx_word[0]} : tx_word;
         sdo_o <= next_sdo; // R25
      end
   end

   // Open-drain output: the pin is pulled low only while a zero bit is shown.
   always_ff @(posedge link_sclk or negedge frame_clr_n) begin
      if (!frame_clr_n) begin
         sdo_oe <= 1'b0;
      end else begin
         sdo_oe <= ~next_sdo; // R25
      end
   end

endmodule : serial_link_shift
`default_nettype wire

// ### tb/digipot_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module digipot_host_model (
   output logic sclk,
   output logic sync_n,
   output logic din,
   input wire logic sdo_oe
);

   // The data-out pad is open drain with a pull-up, so it reads high whenever it is released.
   wire logic pad = sdo_oe ? 1'b0 : 1'b1;

   // The serial clock idles low and stands still between frames.
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      din = 1'b0;
   end

   // Shifts the n lowest bits of w out MSB first at a 12 ns clock and collects the last 16 bits.
   task automatic xfer(input logic [32:0] w, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      sync_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #3 din = w[i];
         #3 sclk = 1'b1;
         #6 sclk = 1'b0;
         rx = {rx[14:0], pad};
      end
      #6 sync_n = 1'b1;
      din = ~din;
   endtask : xfer

endmodule : digipot_host_model

`default_nettype wire

// ### tb/digipot_serial_command_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "digipot_regs.svh"

module digipot_serial_command_ctrl_tb
   import digipot_pkg::*;
;
   localparam int STORE_N = 20;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic reset_pin = 1'b0;
   wire logic sclk, sync_n, din, sdo_oe, ready, shut, sdo_bit, cal;
   wire logic [9:0] wiper, wiper_low;
   wire logic [3:0] ctrl;
   logic [15:0] rx;
   logic [31:0] seed = 32'h0000_511e;
   logic [9:0] exp_w, v;
   int bad_count = 0;
   int compares = 0;

   // The reference clock runs at 10 MHz.
   always #50 ref_clk = ~ref_clk;

   digipot_serial_command_ctrl #(.STORE_CYCLES(STORE_N)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .link_sclk(sclk), .sync_n(sync_n), .din(din),
      .reset_pin(reset_pin), .serial_out_od_o(sdo_bit), .serial_out_od_oe(sdo_oe),
      .ready_o(ready), .wiper_o(wiper), .control_flags_o(ctrl), .shutdown_o(shut),
      .calibration_select_o(cal)
   );

   // Reduced-resolution twin on the same pins; only its wiper is watched.
   digipot_serial_command_ctrl #(.LOW_RES(1'b1), .STORE_CYCLES(STORE_N)) dut_low (
      .ref_clk(ref_clk), .nrst(nrst), .link_sclk(sclk), .sync_n(sync_n), .din(din),
      .reset_pin(reset_pin), .serial_out_od_o(), .serial_out_od_oe(), .ready_o(),
      .wiper_o(wiper_low), .control_flags_o(), .shutdown_o(), .calibration_select_o()
   );

   digipot_host_model host (.sclk(sclk), .sync_n(sync_n), .din(din), .sdo_oe(sdo_oe));

   // Steps the pseudo-random sequence.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Wiper the reduced-resolution variant should hold: the two lowest bits are dropped.
   function automatic logic [9:0] low_res(input logic [9:0] w);
      return {w[9:2], 2'b00};
   endfunction : low_res

   // Builds a well-formed command word.
   function automatic frame_t mk(input logic [3:0] c, input logic [9:0] d);
      return '{2'b00, c, d};
   endfunction : mk

   // Compares one result and reports a mismatch at once.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Sends one command frame, then leaves the decode time to settle.
   task automatic cmd(input logic [3:0] c, input logic [9:0] d);
      host.xfer({17'h0_0000, mk(c, d)}, 16, rx);
      repeat (10) @(negedge ref_clk);
   endtask : cmd

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // Cuts a hang short.
   initial begin
      #2_000_000;
      bad_count++;
      wrap_up();
   end

   // Main sequence.
   initial begin
      repeat (12) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(16'(wiper), 16'(`WIPER_MIDSCALE));
      chk(16'(ctrl), 16'(`CTRL_RESET));
      chk(16'({ready, shut}), 16'h0002);
      cmd(`CMD_WIPER_WRITE, 10'h155);
      chk(16'(wiper), 16'(`WIPER_MIDSCALE));
      cmd(`CMD_CTRL_WRITE, 10'h3F2);
      chk(16'(ctrl), 16'h0002);
      for (int i = 0; i < 14; i++) begin
         seed = lfsr(seed);
         v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : seed[9:0];
         cmd(`CMD_WIPER_WRITE, v);
         cmd(`CMD_WIPER_READ, ~v);
         cmd(`CMD_NOP, ~v);
         chk(16'(wiper), 16'(v));
         chk(16'(wiper_low), 16'(low_res(v)));
         chk(rx, {6'h00, v});
      end
      exp_w = v;
      for (int n = 15; n <= 17; n += 2) begin
         host.xfer({17'h0_0000, mk(`CMD_WIPER_WRITE, 10'h0AA)}, n, rx);
         repeat (10) @(negedge ref_clk);
         chk(16'(wiper), 16'(exp_w));
      end
      host.xfer({17'h0_0000, 16'h4555}, 16, rx);
      repeat (10) @(negedge ref_clk);
      chk(16'(wiper), 16'(exp_w));
      host.xfer({1'b0, mk(`CMD_NOP, 10'h000), mk(`CMD_WIPER_WRITE, 10'h2AA)}, 32, rx);
      repeat (10) @(negedge ref_clk);
      exp_w = 10'h2AA;
      chk(16'(wiper), 16'(exp_w));
      for (int b = 1; b >= 0; b--) begin
         cmd(`CMD_SHUTDOWN, {9'h1FE, b[0]});
         chk(16'({shut, wiper}), 16'({b[0], exp_w}));
      end
      cmd(`CMD_CTRL_WRITE, 10'h007);
      chk(16'(cal), 16'h0001);
      cmd(`CMD_CTRL_READ, 10'h000);
      cmd(`CMD_NOP, 10'h000);
      chk(rx, 16'h0007);
      chk(16'({sdo_bit, sdo_oe}), 16'h0002);
      cmd(`CMD_OTP_STORE, 10'h000);
      chk(16'(ready), 16'h0000);
      host.xfer({17'h0_0000, mk(`CMD_WIPER_WRITE, 10'h001)}, 16, rx);
      for (int k = 0; k < 100 && ready !== 1'b1; k++) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      chk(16'(ready), 16'h0001);
      chk(16'({ctrl, wiper}), 16'({4'hF, exp_w}));
      cmd(`CMD_OTP_READ, 10'h3E0);
      cmd(`CMD_OTP_READ, 10'h014);
      chk(rx, {6'h00, exp_w});
      cmd(`CMD_NOP, 10'h000);
      chk(rx, 16'h0001);
      cmd(`CMD_WIPER_WRITE, 10'h123);
      cmd(`CMD_CTRL_WRITE, 10'h000);
      cmd(`CMD_OTP_RELOAD, 10'h000);
      chk(16'(wiper), 16'(exp_w));
      cmd(`CMD_OTP_STORE, 10'h000);
      chk(16'(ready), 16'h0001);
      cmd(`CMD_CTRL_WRITE, 10'h006);
      cmd(`CMD_WIPER_WRITE, 10'h0F0);
      chk(16'(wiper), 16'h00F0);
      cmd(`CMD_CTRL_WRITE, 10'h003);
      for (int i = 1; i < `OTP_DEPTH; i++) begin
         seed = lfsr(seed);
         exp_w = seed[9:0];
         cmd(`CMD_WIPER_WRITE, exp_w);
         cmd(`CMD_OTP_STORE, 10'h000);
         repeat (25) @(negedge ref_clk);
      end
      cmd(`CMD_OTP_READ, 10'h015);
      cmd(`CMD_OTP_READ, 10'h013);
      chk(rx, 16'h03FF);
      cmd(`CMD_OTP_STORE, 10'h000);
      chk(rx, {6'h00, exp_w});
      chk(16'({ready, ctrl}), 16'h0013);
      v = ~exp_w;
      cmd(`CMD_WIPER_WRITE, v);
      chk(16'(wiper), 16'(v));
      reset_pin = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk(16'({ctrl, wiper}), 16'({4'h0, exp_w}));
      reset_pin = 1'b0;
      nrst = 1'b0;
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(16'(wiper), 16'(`WIPER_MIDSCALE));
      wrap_up();
   end

endmodule : digipot_serial_command_ctrl_tb

`default_nettype wire
